// ==== dsc_params.svh ====
// constants for the decimal seconds counter
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_CMP_W        24
`define DSC_CMP_DEFAULT  24'h989680
`define DSC_SW_LSB       11
`define DSC_SW_W         8
`define DSC_CNT_W        8
`define DSC_DIGIT_WRAP   8'h0A
`define DSC_CNT_RESET    8'h00
`define DSC_DIV_RESET    24'h000000
`endif

// ==== dsc_pkg.sv ====
// types shared by the decimal seconds counter files
`default_nettype none
`include "dsc_params.svh"
package dsc_pkg;
    typedef logic [`DSC_CMP_W-1:0] dsc_cmp_t;
    typedef struct packed {
        logic       dot;
        logic [6:0] seg;
    } dsc_disp_s;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dsc_bidir_s;
endpackage
`default_nettype wire

// ==== dsc_seg_decode.sv ====
// binary digit to seven-segment pattern, segment a in bit 0
`default_nettype none
module dsc_seg_decode
    import dsc_pkg::*;
(
    input  wire logic [3:0] digit,
    output var dsc_disp_s   disp
);
    always_comb begin
        disp.dot = 1'b0;
        case (digit)
            4'h0: disp.seg = 7'h3F;
            4'h1: disp.seg = 7'h06;
            4'h2: disp.seg = 7'h5B;
            4'h3: disp.seg = 7'h4F;
            4'h4: disp.seg = 7'h66;
            4'h5: disp.seg = 7'h6D;
            4'h6: disp.seg = 7'h7D;
            4'h7: disp.seg = 7'h07;
            4'h8: disp.seg = 7'h7F;
            4'h9: disp.seg = 7'h6F;
            default: disp.seg = 7'h00;
        endcase
    end
endmodule
`default_nettype wire

// ==== dsc_counter.sv ====
// decimal seconds counter top: divider, digit counter, display and pin drive
// ===========================================
// Functional notes
// - all switches zero: compare value is 10,000,000 cycles
// - any switch set: switches form compare bits 11 to 18, others zero
// - divider counts clocks; reaching compare minus one advances the count and clears the divider
// - low eight count bits drive the bidirectional pins as outputs
// - count decoded to segments a-g on pins 0-6, dot on pin 7
// - count steps once per divider period, wraps after nine to zero
`default_nettype none
`include "dsc_params.svh"
module dsc_counter
    import dsc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic [`DSC_SW_W-1:0]  switchIn,
    output logic      [7:0]            segOut,
    output logic      [7:0]            countPinOut,
    output logic      [7:0]            countPinOe
);
    // ===========================================
    // switch synchroniser
    logic [`DSC_SW_W-1:0] swMeta_reg;
    logic [`DSC_SW_W-1:0] swSync_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            swMeta_reg <= 8'h00;
            swSync_reg <= 8'h00;
        end else begin
            swMeta_reg <= switchIn;
            swSync_reg <= swMeta_reg;
        end
    end

    // ===========================================
    // compare select
    dsc_cmp_t cmpValue;
    always_comb begin
        if (swSync_reg == 8'h00) begin
            cmpValue = `DSC_CMP_DEFAULT;
        end else begin
            cmpValue = '0;
            cmpValue[`DSC_SW_LSB +: `DSC_SW_W] = swSync_reg;
        end
    end

    // ===========================================
    // divider; >= guards against a compare lowered below the running count
    dsc_cmp_t divCount_reg;
    logic     stepTick;
    assign stepTick = (divCount_reg >= cmpValue - 24'h000001);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divCount_reg <= `DSC_DIV_RESET;
        end else if (stepTick) begin
            divCount_reg <= `DSC_DIV_RESET;
        end else begin
            divCount_reg <= divCount_reg + 24'h000001;
        end
    end

    // ===========================================
    // digit counter
    logic [`DSC_CNT_W-1:0] count_reg;
    logic [`DSC_CNT_W-1:0] count_next;
    always_comb begin
        count_next = count_reg + 8'h01;
        if (count_next >= `DSC_DIGIT_WRAP) begin
            count_next = `DSC_CNT_RESET;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= `DSC_CNT_RESET;
        end else if (stepTick) begin
            count_reg <= count_next;
        end
    end

    // ===========================================
    // outputs, registered from the next count so pins track count_reg
    dsc_disp_s  dispNext;
    dsc_bidir_s bidir_reg;
    dsc_disp_s  disp_reg;
    logic [7:0] shownCount;
    assign shownCount = stepTick ? count_next : count_reg;
    dsc_seg_decode u_decode (
        .digit (shownCount[3:0]),
        .disp  (dispNext)
    );
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            disp_reg      <= '0;
            bidir_reg.out <= 8'h00;
            bidir_reg.oe  <= 8'hFF;
        end else begin
            disp_reg      <= dispNext;
            bidir_reg.out <= shownCount;
            bidir_reg.oe  <= 8'hFF;
        end
    end
    assign segOut      = {disp_reg.dot, disp_reg.seg};
    assign countPinOut = bidir_reg.out;
    assign countPinOe  = bidir_reg.oe;
endmodule
`default_nettype wire

// ==== dsc_counter_props.sv ====
// port assertions for the decimal seconds counter
`default_nettype none
module dsc_counter_props (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic [7:0] switchIn,
    input wire logic [7:0] segOut,
    input wire logic [7:0] countPinOut,
    input wire logic [7:0] countPinOe
);
    // ========
    // cycles since the count last moved; switches must be set during reset
    logic [23:0] gapReg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) gapReg <= 24'hFFFFFF;
        else gapReg <= $changed(countPinOut) ? 24'h000000 : gapReg + 24'h000001;
    a_period_match: assert property ($changed(countPinOut) |-> gapReg ==
        (switchIn == 8'h00 ? 24'h98967F : {5'h00, switchIn, 11'h000} - 24'h000001))
        else $error("step period wrong");
    a_step_next: assert property ($changed(countPinOut) |-> countPinOut ==
        ($past(countPinOut) == 8'h09 ? 8'h00 : $past(countPinOut) + 8'h01)) else $error("bad step");
    a_count_range: assert property (countPinOut <= 8'h09) else $error("count over nine");
    a_pins_driven: assert property (countPinOe == 8'hFF) else $error("pins not driven");
    a_zero_glyph: assert property ($past(rstn) && countPinOut == 8'h00 |-> segOut == 8'h3F)
        else $error("zero glyph wrong");
    a_dot_off: assert property (segOut[7] == 1'b0) else $error("dot lit");
    a_reset_zero: assert property (disable iff (1'b0) !rstn |-> countPinOut == 8'h00)
        else $error("count not cleared");
endmodule
bind dsc_counter dsc_counter_props u_props (.mclk(mclk), .rstn(rstn), .switchIn(switchIn),
    .segOut(segOut), .countPinOut(countPinOut), .countPinOe(countPinOe));
`default_nettype wire

// ==== dsc_panel.sv ====
// switch panel model: presents the rate switches just after each clock edge
`default_nettype none
module dsc_panel (
    input  wire logic       mclk,
    input  wire logic [7:0] want,
    output logic      [7:0] switchIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial switchIn = 8'h00;
    always @(posedge mclk) switchIn <= #1 want;
endmodule
`default_nettype wire

// ==== dsc_counter_test.sv ====
// self-checking bench for the decimal seconds counter
`default_nettype none
module dsc_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rstn = 1'b1;
    logic [7:0] want = 8'h00;
    logic [7:0] switchIn, segOut, countPinOut, countPinOe;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    logic [7:0] rows [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03};
    logic [7:0] glyph [10] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07, 8'h7F, 8'h6F};
    dsc_panel panel (.mclk(mclk), .want(want), .switchIn(switchIn));
    dsc_counter dut (.mclk(mclk), .rstn(rstn), .switchIn(switchIn), .segOut(segOut),
        .countPinOut(countPinOut), .countPinOe(countPinOe));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 80000) begin err_count++; end_sim(); end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic restart(input logic [7:0] sw);
        want = sw;
        rstn = 1'b0;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ========
    // rows: each switch value must step exactly at value times 2048 edges
    initial begin
        foreach (rows[i]) begin
            restart(rows[i]);
            chk(countPinOut, 8'h00);
            repeat (int'(rows[i]) * 2048 - 1) @(posedge mclk);
            #1 chk(countPinOut, 8'h00);
            @(posedge mclk);
            #1 chk(countPinOut, 8'h01);
            chk(segOut, glyph[1]);
            $display("row %0d done", i);
        end
        restart(8'h01);
        for (int d = 1; d <= 10; d++) begin
            repeat (2048) @(posedge mclk);
            #1 chk(countPinOut, 8'(d % 10));
            chk(segOut, glyph[d % 10]);
        end
        $display("wrap test done");
        restart(8'h00);
        chk(countPinOe, 8'hFF);
        repeat (3000) @(posedge mclk);
        #1 chk(countPinOut, 8'h00);
        $display("default rate test done");
        end_sim();
    end
endmodule
`default_nettype wire
